// file: verilog/l2wt_cfg.svh
`ifndef L2WT_CFG_SVH
`define L2WT_CFG_SVH
// Summary of operation
// [RULE1] read hit: first doubleword two clocks after start, three more in three clocks
// [RULE2] a cycle starts only on an active cycle strobe; otherwise stay idle
// [RULE3] address bits 4..15 pick one of 4096 sets; bits 16..31 are the tag
// [RULE4] read hit returns data; unprotected write hit stores the new data
// [RULE5] write miss leaves contents alone; memory sees every write
// [RULE6] no ready is driven on writes; the system ends them
// [RULE7] the system decodes chip select from address bit 16 upward
// [RULE8] the system merges burst ready and forms non-burst ready
// [RULE9] cache-enable out asserted in first bus state, dropped if chip select inactive
// [RULE10] read hit keeps cache-enable out asserted, except protected line with strap low
// [RULE11] read hit asserts burst ready in first second state, per doubleword
// [RULE12] early burst end or non-burst cycle releases burst ready after last data
// [RULE13] read miss asserts memory start and captures data on system readies
// [RULE14] read miss drops cache-enable out in first second state until cycle end
// [RULE15] only a whole cacheable four-doubleword fill validates a line
// [RULE16] a miss whose first doubleword has no wait state is not cached
// [RULE17] I/O cycles are ignored and never raise memory start
// [RULE18] the system asserts both cache enables before the first fill ready
// [RULE19] the system may drop processor cache enable before the last ready
// [RULE20] burst word order is start address xor beat number
// [RULE21] fill data is written in the same clocks as the system readies
// [RULE22] reset clears every valid bit and the control state
// [RULE23] memory start is never asserted with chip select inactive
// [RULE24] write protect sets a line bit; write hits then leave the line unchanged
// [RULE25] system cache enable is sampled at first ready and the clock before last
// [RULE26] fills replace the least recently used way; hits and fills update it; the code updates it on read hits and cached fills; write hits do not
// [RULE27] parity bits are stored and returned with each doubleword unchecked

// address layout
`define L2_SET_LSB 4
`define L2_SET_BITS 12
`define L2_TAG_LSB 16
`define L2_TAG_BITS 16
`define L2_WORD_LSB 2
`define L2_LINE_WORDS 4
`define L2_WAYS 2
`define L2_DATA_BITS 32
`define L2_PAR_BITS 4
// timing counts in clocks and beat numbers
`define L2_HIT_FIRST_CLKS 2
`define L2_WP_BEAT 2'h2
`define L2_LAST_BEAT 2'h3
// reset values of outputs, active low pins idle high except cache enable
`define L2_RDY_RST 1'b1
`define L2_OE_RST 1'b1
`define L2_START_RST 1'b1
`define L2_KEN_RST 1'b0
`endif

// file: verilog/l2wt_pkg.sv
`include "l2wt_cfg.svh"
package l2wt_pkg;
  // bus cycle being followed
  typedef enum logic [2:0] {ST_IDLE, ST_HIT, ST_FILL, ST_WRITE, ST_PASS} mode_t;
  // whole controller state
  typedef struct packed {
    mode_t mode;
    logic [`L2_SET_BITS-1:0] set;
    logic [`L2_TAG_BITS-1:0] tag;
    logic [1:0] start;
    logic [1:0] beat;
    logic way;
    logic first_t2;
    logic ok;
    logic ken_prev;
    logic wp_cap;
    logic [`L2_DATA_BITS-1:0] data;
    logic [`L2_PAR_BITS-1:0] par;
    logic oe_n;
    logic rdy_n;
    logic start_n;
    logic ken_n;
  } ctl_state_t;
endpackage

// file: verilog/l2wt_store.sv
`include "l2wt_cfg.svh"
module l2wt_store #(
  parameter int SET_BITS = `L2_SET_BITS,
  parameter int TAG_BITS = `L2_TAG_BITS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // lookup
  input wire logic [SET_BITS-1:0] rd_set_in,
  input wire logic [TAG_BITS-1:0] rd_tag_in,
  input wire logic rd_way_in,
  input wire logic [1:0] rd_word_in,
  output logic [1:0] hit_out,
  output logic [1:0] valid_out,
  output logic [1:0] wp_out,
  output logic lru_out,
  output logic [35:0] rd_word_data_out,
  // data word write with byte mask
  input wire logic dw_en_in,
  input wire logic dw_way_in,
  input wire logic [SET_BITS-1:0] dw_set_in,
  input wire logic [1:0] dw_word_in,
  input wire logic [3:0] dw_be_in,
  input wire logic [35:0] dw_data_in,
  // tag, valid and protect write
  input wire logic tw_en_in,
  input wire logic tw_way_in,
  input wire logic [SET_BITS-1:0] tw_set_in,
  input wire logic [TAG_BITS-1:0] tw_tag_in,
  input wire logic tw_valid_in,
  input wire logic tw_wp_in,
  // replacement bit write
  input wire logic lru_en_in,
  input wire logic [SET_BITS-1:0] lru_set_in,
  input wire logic lru_val_in
);
  localparam int SETS = 1 << SET_BITS;

  if (SET_BITS + TAG_BITS + `L2_SET_LSB != 32) begin : g_bad_split
    $error("set and tag widths must cover address bits 4 to 31");
  end

  logic [TAG_BITS-1:0] tag_mem [`L2_WAYS][SETS];
  logic valid_mem [`L2_WAYS][SETS];
  logic wp_mem [`L2_WAYS][SETS];
  logic lru_mem [SETS];
  logic [35:0] data_mem [`L2_WAYS][SETS*`L2_LINE_WORDS];

  // tag compare in both ways of the indexed set
  always_comb begin
    for (int w = 0; w < `L2_WAYS; w++) begin
      valid_out[w] = valid_mem[w][rd_set_in];
      wp_out[w] = wp_mem[w][rd_set_in];
      hit_out[w] = valid_out[w] && (tag_mem[w][rd_set_in] == rd_tag_in); // [RULE3]
    end
    lru_out = lru_mem[rd_set_in];
    rd_word_data_out = data_mem[rd_way_in][{rd_set_in, rd_word_in}];
  end

  // valid bits cleared by reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int w = 0; w < `L2_WAYS; w++) begin
        for (int i = 0; i < SETS; i++) begin
          valid_mem[w][i] <= 1'b0; // [RULE22]
        end
      end
    end else if (tw_en_in) begin
      valid_mem[tw_way_in][tw_set_in] <= tw_valid_in;
    end
  end

  // arrays without reset; parity lanes follow their byte lanes
  always_ff @(posedge clk_in) begin
    if (tw_en_in) begin
      tag_mem[tw_way_in][tw_set_in] <= tw_tag_in;
      wp_mem[tw_way_in][tw_set_in] <= tw_wp_in; // [RULE24]
    end
    if (lru_en_in) begin
      lru_mem[lru_set_in] <= lru_val_in;
    end
    for (int b = 0; b < 4; b++) begin
      if (dw_en_in && dw_be_in[b]) begin
        data_mem[dw_way_in][{dw_set_in, dw_word_in}][b*8 +: 8] <= dw_data_in[b*8 +: 8];
        data_mem[dw_way_in][{dw_set_in, dw_word_in}][32+b] <= dw_data_in[32+b]; // [RULE27]
      end
    end
  end
endmodule

// file: verilog/l2_write_through_cache.sv
`include "l2wt_cfg.svh"
module l2_write_through_cache
  import l2wt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // processor cycle control
  input wire logic cycle_strobe_n_in,
  input wire logic mem_io_in,
  input wire logic write_read_in,
  input wire logic [31:2] addr_in,
  input wire logic [3:0] byte_en_n_in,
  input wire logic burst_final_n_in,
  input wire logic chip_sel_n_in,
  // data and parity lanes, shared with the processor
  input wire logic [31:0] data_in,
  input wire logic [3:0] par_in,
  output logic [31:0] data_out,
  output logic [3:0] par_out,
  output logic data_oe_n_out,
  // system readies and cacheability
  input wire logic sys_burst_rdy_in_n_in,
  input wire logic sys_single_rdy_in_n_in,
  input wire logic sys_cacheable_in_n_in,
  input wire logic write_protect_in,
  input wire logic protect_strap_n_in,
  // answers to processor and memory
  output logic hit_burst_rdy_out_n_out,
  output logic cacheable_out_n_out,
  output logic mem_start_n_out
);
  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // doubleword of a burst: start index xor beat number
  function automatic logic [1:0] burst_word(input logic [1:0] first, input logic [1:0] beat);
    burst_word = first ^ beat; // [RULE20]
  endfunction

  // a system ready of either kind
  function automatic logic sys_ready(input logic burst_n, input logic single_n);
    sys_ready = !burst_n || !single_n;
  endfunction

  ctl_state_t s_q, s_d;

  logic [`L2_SET_BITS-1:0] addr_set;
  logic [`L2_TAG_BITS-1:0] addr_tag;
  logic [1:0] addr_word;
  logic [`L2_SET_BITS-1:0] rd_set;
  logic [`L2_TAG_BITS-1:0] rd_tag;
  logic rd_way;
  logic [1:0] rd_word;
  logic [1:0] hit;
  logic [1:0] valid;
  logic [1:0] wp;
  logic lru;
  logic [35:0] rd_data;
  logic hit_wp;
  logic victim;
  logic rdy_now;
  logic ok_now;
  logic dw_en;
  logic [1:0] dw_word;
  logic [3:0] dw_be;
  logic tw_en;
  logic tw_valid;
  logic lru_en;
  logic lru_val;

  ////////////////////////////////////////////////////////////////////////////
  // address split and lookup steering

  // set and tag fields of the live address
  assign addr_set = addr_in[`L2_SET_LSB +: `L2_SET_BITS]; // [RULE3]
  assign addr_tag = addr_in[`L2_TAG_LSB +: `L2_TAG_BITS];
  assign addr_word = addr_in[`L2_WORD_LSB +: 2];

  // idle looks up the live address, a running cycle its captured line
  always_comb begin
    if (s_q.mode == ST_IDLE) begin
      rd_set = addr_set;
      rd_tag = addr_tag;
      rd_way = hit[1];
      rd_word = addr_word;
    end else begin
      rd_set = s_q.set;
      rd_tag = s_q.tag;
      rd_way = s_q.way;
      rd_word = burst_word(s_q.start, 2'(s_q.beat + 2'h1));
    end
  end

  // protect bit of the hit way and the replacement choice
  assign hit_wp = hit[1] ? wp[1] : wp[0];
  assign victim = !valid[0] ? 1'b0 : (!valid[1] ? 1'b1 : lru); // [RULE26]
  assign rdy_now = sys_ready(sys_burst_rdy_in_n_in, sys_single_rdy_in_n_in);
  // first sample of system cache enable, refused with no first wait state
  assign ok_now = !s_q.first_t2 && !sys_cacheable_in_n_in; // [RULE16] [RULE25]

  l2wt_store #(
    .SET_BITS(`L2_SET_BITS),
    .TAG_BITS(`L2_TAG_BITS)
  ) u_store (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .rd_set_in(rd_set),
    .rd_tag_in(rd_tag),
    .rd_way_in(rd_way),
    .rd_word_in(rd_word),
    .hit_out(hit),
    .valid_out(valid),
    .wp_out(wp),
    .lru_out(lru),
    .rd_word_data_out(rd_data),
    .dw_en_in(dw_en),
    .dw_way_in(s_q.way),
    .dw_set_in(s_q.set),
    .dw_word_in(dw_word),
    .dw_be_in(dw_be),
    .dw_data_in({par_in, data_in}),
    .tw_en_in(tw_en),
    .tw_way_in(s_q.way),
    .tw_set_in(s_q.set),
    .tw_tag_in(s_q.tag),
    .tw_valid_in(tw_valid),
    .tw_wp_in(s_q.wp_cap),
    .lru_en_in(lru_en),
    .lru_set_in(rd_set),
    .lru_val_in(lru_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencer

  // next state and array writes
  always_comb begin
    s_d = s_q;
    s_d.first_t2 = 1'b0;
    s_d.ken_prev = sys_cacheable_in_n_in;
    dw_en = 1'b0;
    dw_word = burst_word(s_q.start, s_q.beat);
    dw_be = 4'hF;
    tw_en = 1'b0;
    tw_valid = 1'b0;
    lru_en = 1'b0;
    lru_val = 1'b0;
    case (s_q.mode)
      ST_IDLE: begin
        s_d.rdy_n = 1'b1;
        s_d.oe_n = 1'b1;
        s_d.start_n = 1'b1;
        s_d.ken_n = 1'b0; // [RULE9]
        if (!cycle_strobe_n_in) begin // [RULE2]
          s_d.set = addr_set;
          s_d.tag = addr_tag;
          s_d.start = addr_word;
          s_d.beat = 2'h0;
          s_d.first_t2 = 1'b1;
          s_d.ok = 1'b0;
          s_d.wp_cap = 1'b0;
          if (chip_sel_n_in || !mem_io_in) begin
            // deselected or I/O: follow the cycle silently
            s_d.mode = ST_PASS; // [RULE17] [RULE23]
            s_d.ken_n = 1'b1; // [RULE9]
          end else if (write_read_in) begin
            s_d.mode = ST_WRITE;
            s_d.start_n = 1'b0; // [RULE5]
            s_d.ken_n = 1'b1;
            s_d.way = hit[1];
            s_d.ok = (|hit) && !hit_wp; // [RULE24]
          end else if (|hit) begin
            s_d.mode = ST_HIT;
            s_d.way = hit[1];
            s_d.rdy_n = 1'b0; // [RULE11]
            s_d.oe_n = 1'b0;
            s_d.data = rd_data[31:0]; // [RULE4]
            s_d.par = rd_data[35:32]; // [RULE27]
            s_d.ken_n = hit_wp && !protect_strap_n_in; // [RULE10]
            lru_en = 1'b1; // [RULE26]
            lru_val = !hit[1];
          end else begin
            s_d.mode = ST_FILL;
            s_d.start_n = 1'b0; // [RULE13]
            s_d.ken_n = 1'b1; // [RULE14]
            s_d.way = victim;
          end
        end
      end
      ST_HIT: begin
        if (!burst_final_n_in || s_q.beat == `L2_LAST_BEAT) begin
          s_d.mode = ST_IDLE;
          s_d.rdy_n = 1'b1; // [RULE12]
          s_d.oe_n = 1'b1;
          s_d.ken_n = 1'b0;
        end else begin
          s_d.beat = 2'(s_q.beat + 2'h1); // [RULE1]
          s_d.data = rd_data[31:0];
          s_d.par = rd_data[35:32];
        end
      end
      ST_FILL: begin
        s_d.start_n = 1'b1;
        if (rdy_now) begin
          // capture in the clock the system hands data to the processor
          dw_en = (s_q.beat == 2'h0) ? ok_now : s_q.ok; // [RULE13] [RULE21]
          if (s_q.beat == 2'h0) begin
            s_d.ok = ok_now;
            tw_en = ok_now; // [RULE15]
            tw_valid = 1'b0;
          end
          if (s_q.beat == `L2_WP_BEAT) begin
            s_d.wp_cap = write_protect_in; // [RULE24]
          end
          if (s_q.beat == `L2_LAST_BEAT) begin
            // second sample was taken one clock before this last ready
            tw_en = s_q.ok && !s_q.ken_prev; // [RULE15] [RULE25]
            tw_valid = 1'b1;
            lru_en = tw_en; // [RULE26]
            lru_val = !s_q.way;
            s_d.ok = 1'b0;
          end else begin
            s_d.beat = 2'(s_q.beat + 2'h1);
          end
          if (!burst_final_n_in) begin
            s_d.mode = ST_IDLE;
            s_d.ken_n = 1'b0;
          end
        end
      end
      ST_WRITE: begin
        s_d.start_n = 1'b1;
        // write data is on the lanes in the first second state
        if (s_q.first_t2 && s_q.ok) begin
          dw_en = 1'b1; // [RULE4]
          dw_word = s_q.start;
          dw_be = ~byte_en_n_in;
        end
        if (rdy_now && !burst_final_n_in) begin // [RULE6]
          s_d.mode = ST_IDLE;
          s_d.ken_n = 1'b0;
        end
      end
      ST_PASS: begin
        if (rdy_now && !burst_final_n_in) begin
          s_d.mode = ST_IDLE;
          s_d.ken_n = 1'b0;
        end
      end
      default: begin
        s_d.mode = ST_IDLE;
      end
    endcase
  end

  // reset image of the state, a constant so the async branch loads no logic
  localparam ctl_state_t RST_STATE = '{mode: ST_IDLE, set: '0, tag: '0, start: 2'h0,
    beat: 2'h0, way: 1'b0, first_t2: 1'b0, ok: 1'b0, ken_prev: 1'b1, wp_cap: 1'b0,
    data: '0, par: '0, oe_n: `L2_OE_RST, rdy_n: `L2_RDY_RST, start_n: `L2_START_RST,
    ken_n: `L2_KEN_RST};

  // state register
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= RST_STATE; // [RULE22]
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign data_out = s_q.data;
  assign par_out = s_q.par;
  assign data_oe_n_out = s_q.oe_n;
  assign hit_burst_rdy_out_n_out = s_q.rdy_n;
  assign cacheable_out_n_out = s_q.ken_n;
  assign mem_start_n_out = s_q.start_n;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_cycle_begin;
    s_q.mode == ST_IDLE && !cycle_strobe_n_in && !chip_sel_n_in && mem_io_in;
  endsequence

  sequence s_read_hit_begin;
    s_cycle_begin ##0 (!write_read_in && (|hit));
  endsequence

  sequence s_read_miss_begin;
    s_cycle_begin ##0 (!write_read_in && !(|hit));
  endsequence

  chk_idle_quiet: assert property ( // [RULE2]
    (s_q.mode == ST_IDLE && cycle_strobe_n_in) |=>
      (hit_burst_rdy_out_n_out && mem_start_n_out && s_q.mode == ST_IDLE))
    else $error("cycle started without strobe");

  chk_hit_first_data: assert property ( // [RULE1]
    s_read_hit_begin |=> (!hit_burst_rdy_out_n_out && !data_oe_n_out))
    else $error("read hit first doubleword late");

  chk_hit_ken_held: assert property ( // [RULE10]
    s_read_hit_begin ##0 (!hit_wp || protect_strap_n_in) |=> !cacheable_out_n_out)
    else $error("cache enable dropped on an unprotected read hit");

  chk_hit_full_burst: assert property ( // [RULE11]
    s_read_hit_begin ##1 (burst_final_n_in && !hit_burst_rdy_out_n_out)[*3] |=>
      !hit_burst_rdy_out_n_out ##1 hit_burst_rdy_out_n_out)
    else $error("read hit burst length wrong");

  chk_early_release: assert property ( // [RULE12]
    (!hit_burst_rdy_out_n_out && !burst_final_n_in) |=>
      (hit_burst_rdy_out_n_out && data_oe_n_out))
    else $error("burst ready held after last data");

  chk_no_io_start: assert property ( // [RULE17]
    (s_q.mode == ST_IDLE && !cycle_strobe_n_in && !mem_io_in) |=>
      mem_start_n_out [*2])
    else $error("memory start on an I/O cycle");

  chk_start_select: assert property ( // [RULE23]
    !mem_start_n_out |-> $past(!chip_sel_n_in && !cycle_strobe_n_in))
    else $error("memory start without chip select");

  chk_miss_start: assert property ( // [RULE14]
    s_read_miss_begin |=> (!mem_start_n_out && cacheable_out_n_out) ##1 mem_start_n_out)
    else $error("read miss start or cache enable wrong");

  chk_first_state_ken: assert property ( // [RULE9]
    (s_q.mode == ST_IDLE) |-> !cacheable_out_n_out)
    else $error("cache enable not asserted in first bus state");

  chk_write_no_ready: assert property ( // [RULE6]
    (s_q.mode == ST_WRITE) |-> (hit_burst_rdy_out_n_out && data_oe_n_out))
    else $error("ready or data driven on a write");

  chk_fill_no_fast: assert property ( // [RULE16]
    (s_q.mode == ST_FILL && s_q.first_t2 && rdy_now) |-> !tw_en && !dw_en)
    else $error("zero wait fill written into the arrays");
endmodule

// file: testbench/sys_mem_model.sv
module sys_mem_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // processor cycle seen on the bus
  input wire logic strobe_n_in,
  input wire logic [31:2] addr_in,
  // how the system answers
  input wire logic serve_in,
  input wire logic wr_in,
  input wire logic burst_in,
  input wire logic [3:0] waits_in,
  input wire logic [2:0] beats_in,
  input wire logic noncache_in,
  input wire logic late_drop_in,
  // system side lines
  output logic cpu_burst_rdy_n_n_out,
  output logic rdy_n_out,
  output logic last_n_out,
  output logic sys_cacheable_in_n_n_out,
  output logic drv_out,
  output logic [35:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic act_q;
  logic [3:0] cnt_q;
  logic [2:0] k_q;
  logic [35:0] last_q;
  logic go;
  logic [1:0] x;
  ////////////////////////////////////////////////////////////////
  // readies come once the chosen wait states have passed
  assign go = act_q && (cnt_q > waits_in);
  assign cpu_burst_rdy_n_n_out = !(go && burst_in);
  assign rdy_n_out = !(go && !burst_in);
  assign last_n_out = !(go && (k_q == beats_in - 3'h1));
  // cacheable from the start, optionally dropped the clock before the last ready
  assign sys_cacheable_in_n_n_out = noncache_in || (late_drop_in && k_q == 3'h2);
  // fill words follow the processor burst order
  assign x = addr_in[3:2] ^ k_q[1:0];
  assign drv_out = go && !wr_in;
  // a released bus shows the inverse of the last word, never a stale copy
  assign bus_out = drv_out ? {2'h2, x, addr_in[31:4], x, 2'h1} : ~last_q;
  ////////////////////////////////////////////////////////////////
  // cycle tracking; writes and I/O cycles are ended here too
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      act_q <= 1'b0;
      cnt_q <= 4'h0;
      k_q <= 3'h0;
      last_q <= 36'h0;
    end else if (!act_q) begin
      act_q <= serve_in && !strobe_n_in;
      cnt_q <= 4'h1;
      k_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (go) begin
        k_q <= k_q + 3'h1;
        act_q <= last_n_out;
      end
      if (drv_out) begin
        last_q <= bus_out;
      end
    end
  end
endmodule

// file: testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in, rstn_in, strobe_n, mem_r, wr_r, bl_n, svc, burst, nc, late, wp_r, strap_n;
  logic [31:2] addr;
  logic [3:0] be_n, waits;
  logic [2:0] beats;
  logic [35:0] wdat, mbus, nrdy, nst, nkh, f0, ken1, ncy;
  logic [31:0] data_out;
  logic [3:0] par_out;
  logic oe_n, hrdy_n, ken_n, start_n, cpu_burst_rdy_n_n, rdy_n, last_n, sys_cacheable_in_n_n;
  logic [35:0] got [4];
  int fails, checks_done;
  wire logic [35:0] bus_w;
  ////////////////////////////////////////////////////////////////
  // processor write data or system read data on the shared lanes
  assign bus_w = wr_r ? wdat : mbus;
  l2_write_through_cache DUT (.clk_in(clk_in), .rstn_in(rstn_in), .cycle_strobe_n_in(strobe_n),
    .mem_io_in(mem_r), .write_read_in(wr_r), .addr_in(addr), .byte_en_n_in(be_n),
    .burst_final_n_in(svc ? last_n : bl_n), .chip_sel_n_in(addr[16]),
    .data_in(bus_w[31:0]), .par_in(bus_w[35:32]), .data_out(data_out), .par_out(par_out),
    .data_oe_n_out(oe_n), .sys_burst_rdy_in_n_in(cpu_burst_rdy_n_n), .sys_single_rdy_in_n_in(rdy_n),
    .sys_cacheable_in_n_in(sys_cacheable_in_n_n), .write_protect_in(wp_r), .protect_strap_n_in(strap_n),
    .hit_burst_rdy_out_n_out(hrdy_n), .cacheable_out_n_out(ken_n), .mem_start_n_out(start_n));
  sys_mem_model M (.clk_in(clk_in), .rstn_in(rstn_in), .strobe_n_in(strobe_n), .addr_in(addr),
    .serve_in(svc), .wr_in(wr_r), .burst_in(burst), .waits_in(waits), .beats_in(beats),
    .noncache_in(nc), .late_drop_in(late), .cpu_burst_rdy_n_n_out(cpu_burst_rdy_n_n), .rdy_n_out(rdy_n),
    .last_n_out(last_n), .sys_cacheable_in_n_n_out(sys_cacheable_in_n_n), .drv_out(), .bus_out(mbus));
  // clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [35:0] wv(input logic [31:2] a, input logic [1:0] x);
    return {2'h2, x, a[31:4], x, 2'h1};
  endfunction
  function automatic logic [31:2] ad(input logic [15:0] t, input logic [11:0] s,
      input logic [1:0] w);
    return {t, s, w};
  endfunction
  task automatic cmp(input logic [35:0] g, input logic [35:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one processor cycle, observed at falling edges until the merged ready ends it
  task automatic bus(input logic w, input logic m, input logic [31:2] a, input logic [35:0] d,
      input logic s, input logic [3:0] wt, input logic [2:0] nb, input logic n, input logic l);
    logic fin;
    @(negedge clk_in);
    strobe_n = 1'b0;
    {wr_r, mem_r, addr, wdat, svc, waits, beats, nc, late} = {w, m, a, d, s, wt, nb, n, l};
    burst = !w && m;
    {nrdy, nst, nkh, f0, fin, ncy} = {144'h0, 1'b0, 36'h1};
    @(negedge clk_in);
    strobe_n = 1'b1;
    ken1 = {35'h0, ken_n};
    while (!fin) begin
      if (start_n === 1'b0) nst++;
      if (ken_n !== 1'b0) nkh++;
      if (hrdy_n === 1'b0) begin
        if (nrdy == 0) f0 = ncy;
        got[nrdy[1:0]] = {par_out, data_out};
        bl_n = (nrdy[2:0] != nb - 3'h1);
        nrdy++;
      end
      // the processor sees the merged ready of cache and system
      fin = !(hrdy_n && cpu_burst_rdy_n_n && rdy_n) && !(s ? last_n : bl_n);
      @(negedge clk_in);
      ncy++;
      if (ncy > 36'h28) begin
        fails++;
        finish_test();
      end
    end
    bl_n = 1'b1;
  endtask
  task automatic fill(input logic [31:2] a, input logic [3:0] wt, input logic n, input logic l);
    bus(1'b0, 1'b1, a, 36'h0, 1'b1, wt, 3'h4, n, l);
  endtask
  task automatic miss_chk(input logic [31:2] a);
    fill(a, 4'h1, 1'b1, 1'b0);
    cmp({nst[3:0], nrdy[3:0]}, 36'h10);
  endtask
  task automatic hit_chk(input logic [31:2] a, input logic [1:0] mx, input logic [35:0] mv,
      input logic mo);
    logic [1:0] x;
    bus(1'b0, 1'b1, a, 36'h0, 1'b0, 4'h0, 3'h4, 1'b0, 1'b0);
    cmp({16'h0, f0[3:0], ncy[3:0], nrdy[3:0], nst[3:0], nkh[3:0]}, 36'h15400);
    for (int k = 0; k < 4; k++) begin
      x = a[3:2] ^ 2'(k);
      cmp(got[k], (mo && x == mx) ? mv : wv(a, x));
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    cmp({hrdy_n, start_n, oe_n, ken_n}, 36'hE);
    miss_chk(ad(16'h0002, 12'h001, 2'h0));
    $display("reset test done");
  endtask
  task automatic t_fill_hit();
    fill(ad(16'h0004, 12'h010, 2'h1), 4'h1, 1'b0, 1'b0);
    cmp({nst[3:0], ken1[3:0]}, 36'h11);
    cmp(nkh, ncy - 36'h1);
    hit_chk(ad(16'h0004, 12'h010, 2'h2), 2'h0, 36'h0, 1'b0);
    miss_chk(ad(16'h0004, 12'h011, 2'h0));
    $display("fill and hit test done");
  endtask
  task automatic t_no_fill();
    fill(ad(16'h0008, 12'h012, 2'h0), 4'h0, 1'b0, 1'b0);
    miss_chk(ad(16'h0008, 12'h012, 2'h0));
    fill(ad(16'h0008, 12'h013, 2'h3), 4'h2, 1'b1, 1'b0);
    miss_chk(ad(16'h0008, 12'h013, 2'h3));
    fill(ad(16'h0008, 12'h014, 2'h1), 4'h1, 1'b0, 1'b1);
    miss_chk(ad(16'h0008, 12'h014, 2'h1));
    bus(1'b0, 1'b1, ad(16'h0008, 12'h015, 2'h0), 36'h0, 1'b1, 4'h1, 3'h2, 1'b0, 1'b0);
    miss_chk(ad(16'h0008, 12'h015, 2'h0));
    $display("uncached fill test done");
  endtask
  task automatic t_early();
    for (int nb = 1; nb < 3; nb++) begin
      bus(1'b0, 1'b1, ad(16'h0004, 12'h010, 2'h3), 36'h0, 1'b0, 4'h0, 3'(nb), 1'b0, 1'b0);
      cmp({nrdy[3:0], 3'h0, hrdy_n}, {4'(nb), 4'h1});
    end
    $display("early end test done");
  endtask
  task automatic t_write();
    logic [31:2] a;
    logic [35:0] o;
    a = ad(16'h0004, 12'h010, 2'h3);
    o = wv(a, 2'h3);
    be_n = 4'hC;
    bus(1'b1, 1'b1, a, 36'h9_1234_5678, 1'b1, 4'h1, 3'h1, 1'b0, 1'b0);
    cmp({nst[3:0], nrdy[3:0]}, 36'h10);
    hit_chk(a, 2'h3, {o[35:34], 2'h1, o[31:16], 16'h5678}, 1'b1);
    bus(1'b1, 1'b1, ad(16'h0006, 12'h020, 2'h0), 36'h0, 1'b1, 4'h2, 3'h1, 1'b0, 1'b0);
    miss_chk(ad(16'h0006, 12'h020, 2'h0));
    be_n = 4'h0;
    $display("write test done");
  endtask
  task automatic t_bypass();
    bus(1'b0, 1'b0, ad(16'h0004, 12'h010, 2'h0), 36'h0, 1'b1, 4'h1, 3'h1, 1'b1, 1'b0);
    cmp({nst[3:0], nrdy[3:0]}, 36'h0);
    bus(1'b0, 1'b1, ad(16'h0005, 12'h010, 2'h0), 36'h0, 1'b1, 4'h1, 3'h4, 1'b0, 1'b0);
    cmp({nst[3:0], nrdy[3:0], ken1[3:0]}, 36'h1);
    for (int k = 0; k < 10; k++) begin
      @(negedge clk_in);
      cmp({start_n, hrdy_n, oe_n}, 36'h7);
    end
    $display("bypass and idle test done");
  endtask
  task automatic t_protect();
    logic [31:2] a;
    a = ad(16'h000A, 12'h022, 2'h2);
    wp_r = 1'b1;
    fill(a, 4'h1, 1'b0, 1'b0);
    wp_r = 1'b0;
    strap_n = 1'b0;
    bus(1'b0, 1'b1, a, 36'h0, 1'b0, 4'h0, 3'h4, 1'b0, 1'b0);
    cmp({nrdy[3:0], 3'h0, nkh != 0}, 36'h41);
    bus(1'b1, 1'b1, a, 36'h0, 1'b1, 4'h1, 3'h1, 1'b0, 1'b0);
    strap_n = 1'b1;
    hit_chk(a, 2'h0, 36'h0, 1'b0);
    $display("protect test done");
  endtask
  task automatic t_lru();
    fill(ad(16'h0010, 12'h030, 2'h0), 4'h1, 1'b0, 1'b0);
    fill(ad(16'h0020, 12'h030, 2'h0), 4'h1, 1'b0, 1'b0);
    hit_chk(ad(16'h0010, 12'h030, 2'h1), 2'h0, 36'h0, 1'b0);
    fill(ad(16'h0030, 12'h030, 2'h0), 4'h1, 1'b0, 1'b0);
    miss_chk(ad(16'h0020, 12'h030, 2'h0));
    hit_chk(ad(16'h0010, 12'h030, 2'h0), 2'h0, 36'h0, 1'b0);
    hit_chk(ad(16'h0030, 12'h030, 2'h3), 2'h0, 36'h0, 1'b0);
    $display("replacement test done");
  endtask
  ////////////////////////////////////////////////////////////////
  // reset, then the scenarios in order
  initial begin
    {rstn_in, strobe_n, mem_r, wr_r, bl_n, svc, burst, nc, late, wp_r, strap_n} = 11'h241;
    {addr, be_n, waits, beats, wdat} = 77'h0;
    fails = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_in);
    @(negedge clk_in);
    rstn_in = 1'b1;
    t_reset();
    t_fill_hit();
    t_no_fill();
    t_early();
    t_write();
    t_bypass();
    t_protect();
    t_lru();
    finish_test();
  end
endmodule
